/* pkg/dtcc_map.svh */
// register offsets, field positions, reset values and timing counts of the capture/compare array
`ifndef DTCC_MAP_SVH
`define DTCC_MAP_SVH
`define DTCC_NCH 16
`define DTCC_ADDR_W 6
// word addresses: per-channel register value 0x00..0x0F, per-channel mode 0x10..0x1F
`define DTCC_OFF_VAL 6'h00
`define DTCC_OFF_MODE 6'h10
`define DTCC_OFF_TA_CNT 6'h20
`define DTCC_OFF_TA_REL 6'h21
`define DTCC_OFF_TB_CNT 6'h22
`define DTCC_OFF_TB_REL 6'h23
`define DTCC_OFF_TA_CTL 6'h24
`define DTCC_OFF_TB_CTL 6'h25
`define DTCC_OFF_FLAGS 6'h26
`define DTCC_OFF_GLOBAL 6'h27
// channel mode word fields
`define DTCC_MODE_FN_LSB 0
`define DTCC_MODE_TSEL_BIT 3
`define DTCC_MODE_SINGLE_BIT 4
`define DTCC_MODE_DOUBLE_BIT 5
`define DTCC_MODE_EDGE_LSB 6
// timer control fields: bit0 run, bits3:1 source
`define DTCC_TCTL_RUN_BIT 0
`define DTCC_TCTL_SRC_LSB 1
// global control: bit0 staggered
`define DTCC_GLB_STAG_BIT 0
`define DTCC_STAG_CYCLES 8
`define DTCC_RESET_WORD 16'h0000
`endif

/* pkg/dtcc_pkg.sv */
// types shared by the capture/compare array
package dtcc_pkg;
   // channel function: compare modes 0..3, capture, off
   typedef enum logic [2:0] {
      DTCC_CMP0 = 3'h0,
      DTCC_CMP1 = 3'h1,
      DTCC_CMP2 = 3'h2,
      DTCC_CMP3 = 3'h3,
      DTCC_CAPT = 3'h4,
      DTCC_OFF = 3'h7
   } dtcc_fn_type;
   typedef enum logic [1:0] {
      DTCC_EDGE_RISE = 2'h1,
      DTCC_EDGE_FALL = 2'h2,
      DTCC_EDGE_BOTH = 2'h3
   } dtcc_edge_type;
   // timer clock sources
   typedef enum logic [2:0] {
      DTCC_SRC_DIV8 = 3'h0,
      DTCC_SRC_DIV16 = 3'h1,
      DTCC_SRC_DIV32 = 3'h2,
      DTCC_SRC_DIV64 = 3'h3,
      DTCC_SRC_OVF = 3'h4,
      DTCC_SRC_EXT = 3'h5,
      DTCC_SRC_DIV1 = 3'h6
   } dtcc_src_type;
   typedef struct packed {
      dtcc_edge_type trig;
      logic dbl;
      logic single;
      logic tsel;
      dtcc_fn_type fn;
   } dtcc_mode_type;
   // register bus request
   typedef struct packed {
      logic [5:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } dtcc_bus_type;
endpackage

/* logic/dtcc_array.sv */
// dual time base 16-channel capture/compare array with register port
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dtcc_map.svh"
module dtcc_array (
   input wire logic CLK,
   input wire logic RST_B,
   input wire dtcc_pkg::dtcc_bus_type BUS,
   output logic [15:0] RDATA,
   input wire logic OVF_TICK,
   input wire logic EXT_COUNT,
   input wire logic [15:0] PIN_IN,
   output logic [15:0] PIN_OUT,
   output logic [15:0] PIN_OE
);
   import dtcc_pkg::*;

   localparam int NCH = `DTCC_NCH;

   // register map, one 16-bit word per address
   //   0x00..0x0F value of channel n: compare target, or the count a capture took
   //   0x10..0x1F mode byte of channel n; the upper byte is not stored and reads zero
   //   0x20 time_base_a count, writable at any time; a write beats a tick
   //   0x21 time_base_a reload, loaded into the count by the tick that overflows
   //   0x22 time_base_b count
   //   0x23 time_base_b reload
   //   0x24 time_base_a control
   //   0x25 time_base_b control
   //   0x26 request flags, one per channel, write one to clear
   //   0x27 global control, bit 0 selects staggered mode
   //   anything above 0x27 reads zero and ignores writes
   // mode byte
   //   [2:0] function: 0..3 compare modes, 4 capture, 7 off; 5 and 6 act as off
   //   [3] time base select: 0 picks time_base_a, 1 picks time_base_b
   //   [4] single event: after its first compare hit the channel makes no more hits; captures still run
   //   [5] double register: channels 2k and 2k+1 share pin 2k
   //   [7:6] capture trigger: 1 rising, 2 falling, 3 either edge, 0 never
   // timer control word
   //   [0] run; a stopped timer holds its count and still takes writes
   //   [3:1] clock source: 0 /8, 1 /16, 2 /32, 3 /64, 4 general timer overflow,
   //         5 external count rising edge (time_base_a only), 6 every clock;
   //         7 is not decoded and leaves the timer standing
   // timing
   //   a tick seen with count 0xFFFF is the overflow tick: it loads the reload value
   //   a compare hit needs a tick and count equal to value, taken before the step,
   //   so pin and flag move at the same edge that advances the timer
   //   staggered mode holds the clock-derived sources to one tick per eight clocks;
   //   overflow ticks and the external count are events and pass straight through
   //   a capture samples the pin as it arrives; the pin must already be clean
   //   and synchronous, since no synchroniser sits in front of the edge test
   // limitations
   //   the prescaler runs free from reset, so the first prescaled tick after a
   //   start may come anywhere inside the first division period
   //   a value write and a capture in one cycle: the capture is kept
   //   a flag clear and a new event in one cycle: the flag stays set
   //   rewriting a mode byte re-arms single-event and once-per-period channels
   //   in double mode the odd channel's own pin is released for other use

   // register contents, written by software or by captures
   logic [15:0] val_ff [NCH];
   dtcc_mode_type mode_ff [NCH];
   logic [15:0] tmr_ff [2];
   logic [15:0] rel_ff [2];
   logic [3:0] tctl_ff [2];
   logic stag_ff;
   // event state per channel
   logic [15:0] flag_ff;
   logic [15:0] fired_ff;
   logic [15:0] pin_ff;
   logic [15:0] pin_prev_ff;
   // free-running dividers and input edge history
   logic [5:0] pre_ff;
   logic [2:0] stag_cnt_ff;
   logic ext_prev_ff;
   logic [15:0] rdata_ff;
   // combinational event lines, one bit per time base or channel
   logic [1:0] tick;
   logic [1:0] ovf;
   logic [15:0] hit;
   logic [15:0] cap;
   logic [15:0] clr_fired;
   logic [15:0] pin_tog;
   logic [15:0] pin_set;
   logic [15:0] pin_clr;
   logic ext_rise;
   logic stag_en;

   // word address decode, used by several write processes
   function automatic logic wr_hit(input dtcc_bus_type b, input logic [5:0] a);
      wr_hit = b.wr && (b.addr == a);
   endfunction

   // edge test on a captured pin against its chosen trigger
   function automatic logic edge_match(input dtcc_edge_type e, input logic now,
                                       input logic prev);
      edge_match = (e[0] && now && !prev) || (e[1] && !now && prev);
   endfunction

   // system clock prescaler and staggered-mode slot counter
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pre_ff <= 6'h00;
         stag_cnt_ff <= 3'h0;
         ext_prev_ff <= 1'b0;
      end else begin
         pre_ff <= pre_ff + 6'h01;
         stag_cnt_ff <= stag_cnt_ff + 3'h1;
         ext_prev_ff <= EXT_COUNT;
      end
   end

   // staggered mode only lets clock-derived ticks through once every eight cycles
   assign stag_en = !stag_ff || (stag_cnt_ff == 3'(`DTCC_STAG_CYCLES - 1));
   assign ext_rise = EXT_COUNT && !ext_prev_ff;

   // count enables and overflow per time base
   genvar t;
   generate
      for (t = 0; t < 2; t++) begin : g_tmr
         dtcc_src_type src;
         logic raw;
         assign src = dtcc_src_type'(tctl_ff[t][`DTCC_TCTL_SRC_LSB +: 3]);
         always_comb begin
            case (src)
               DTCC_SRC_DIV1: raw = 1'b1;
               DTCC_SRC_DIV8: raw = (pre_ff[2:0] == 3'h7);
               DTCC_SRC_DIV16: raw = (pre_ff[3:0] == 4'hF);
               DTCC_SRC_DIV32: raw = (pre_ff[4:0] == 5'h1F);
               DTCC_SRC_DIV64: raw = (pre_ff == 6'h3F);
               DTCC_SRC_OVF: raw = OVF_TICK;
               DTCC_SRC_EXT: raw = (t == 0) ? ext_rise : 1'b0;
               default: raw = 1'b0;
            endcase
         end
         // external events are not held back by staggering, prescaled ticks are
         assign tick[t] = tctl_ff[t][`DTCC_TCTL_RUN_BIT] && raw &&
                          (src == DTCC_SRC_OVF || src == DTCC_SRC_EXT || stag_en);
         assign ovf[t] = tick[t] && (tmr_ff[t] == 16'hFFFF);

         // timer count with reload on overflow; software write wins over a count
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
               tmr_ff[t] <= `DTCC_RESET_WORD;
               rel_ff[t] <= `DTCC_RESET_WORD;
               tctl_ff[t] <= 4'h0;
            end else begin
               if (wr_hit(BUS, 6'(`DTCC_OFF_TA_CNT + 2 * t))) begin
                  tmr_ff[t] <= BUS.wdata;
               end else if (ovf[t]) begin
                  tmr_ff[t] <= rel_ff[t];
               end else if (tick[t]) begin
                  tmr_ff[t] <= tmr_ff[t] + 16'h0001;
               end
               if (wr_hit(BUS, 6'(`DTCC_OFF_TA_REL + 2 * t))) begin
                  rel_ff[t] <= BUS.wdata;
               end
               if (wr_hit(BUS, 6'(`DTCC_OFF_TA_CTL + t))) begin
                  tctl_ff[t] <= BUS.wdata[3:0];
               end
            end
         end
      end
   endgenerate

   // per-channel compare and capture decision
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic ts;
         logic cmp;
         logic once;
         logic blocked;
         // in double mode the odd channel drives its even partner's pin
         assign ts = mode_ff[c].tsel;
         assign once = (mode_ff[c].fn == DTCC_CMP2) || (mode_ff[c].fn == DTCC_CMP3);
         assign blocked = fired_ff[c] && (once || mode_ff[c].single);
         assign cmp = !mode_ff[c].fn[2] && tick[ts] &&
                      (tmr_ff[ts] == val_ff[c]);
         assign hit[c] = cmp && !blocked;
         assign cap[c] = (mode_ff[c].fn == DTCC_CAPT) &&
                         edge_match(mode_ff[c].trig, PIN_IN[c], pin_prev_ff[c]);
         // single-event channels stay stopped until software rewrites the mode
         assign clr_fired[c] = ovf[ts] && once && !mode_ff[c].single;
         // toggling is gathered at the pin that the channel drives
         assign pin_tog[c] = (hit[c] && mode_ff[c].fn == DTCC_CMP1 && !mode_ff[c].dbl) ||
                             (hit[c] && mode_ff[c].dbl && !mode_ff[c].fn[2] &&
                              (c % 2 == 0)) ||
                             (hit[c ^ 1] && mode_ff[c ^ 1].dbl &&
                              !mode_ff[c ^ 1].fn[2] && (c % 2 == 0));
         assign pin_set[c] = hit[c] && (mode_ff[c].fn == DTCC_CMP3);
         assign pin_clr[c] = ovf[ts] && (mode_ff[c].fn == DTCC_CMP3);
         // pins drive only when the channel, or its odd partner in double mode, compares with an output mode
         assign PIN_OE[c] = (!mode_ff[c].dbl &&
                             (mode_ff[c].fn == DTCC_CMP1 || mode_ff[c].fn == DTCC_CMP3)) ||
                            ((c % 2 == 0) && mode_ff[c].dbl && !mode_ff[c].fn[2]) ||
                            ((c % 2 == 0) && mode_ff[c ^ 1].dbl &&
                             !mode_ff[c ^ 1].fn[2]);
      end
   endgenerate

   // channel values: capture load beats a same-cycle software write
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < NCH; i++) begin
            val_ff[i] <= `DTCC_RESET_WORD;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap[i]) begin
               val_ff[i] <= tmr_ff[mode_ff[i].tsel];
            end else if (wr_hit(BUS, 6'(`DTCC_OFF_VAL + i))) begin
               val_ff[i] <= BUS.wdata;
            end
         end
      end
   end

   // channel modes; writing a mode also re-arms the once-only mark
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < NCH; i++) begin
            mode_ff[i] <= '{trig: DTCC_EDGE_RISE, dbl: 1'b0, single: 1'b0,
                            tsel: 1'b0, fn: DTCC_OFF};
         end
         stag_ff <= 1'b0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_hit(BUS, 6'(`DTCC_OFF_MODE + i))) begin
               mode_ff[i] <= dtcc_mode_type'(BUS.wdata[7:0]);
            end
         end
         if (wr_hit(BUS, `DTCC_OFF_GLOBAL)) begin
            stag_ff <= BUS.wdata[`DTCC_GLB_STAG_BIT];
         end
      end
   end

   // fired marks: set on a compare hit, cleared at mode write or, for once-per-period channels, at overflow; set wins
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fired_ff <= 16'h0000;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (hit[i]) begin
               fired_ff[i] <= 1'b1;
            end else if (clr_fired[i] || wr_hit(BUS, 6'(`DTCC_OFF_MODE + i))) begin
               fired_ff[i] <= 1'b0;
            end
         end
      end
   end

   // request flags: write one to clear, a new event in the same cycle wins
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         flag_ff <= 16'h0000;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap[i] || hit[i]) begin
               flag_ff[i] <= 1'b1;
            end else if (wr_hit(BUS, `DTCC_OFF_FLAGS) && BUS.wdata[i]) begin
               flag_ff[i] <= 1'b0;
            end
         end
      end
   end

   // output pin levels; mode 0 and 2 touch the pin only in double mode
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_ff <= 16'h0000;
         pin_prev_ff <= 16'h0000;
      end else begin
         pin_prev_ff <= PIN_IN;
         for (int i = 0; i < NCH; i++) begin
            if (pin_set[i]) begin
               pin_ff[i] <= 1'b1;
            end else if (pin_clr[i]) begin
               pin_ff[i] <= 1'b0;
            end else if (pin_tog[i]) begin
               pin_ff[i] <= !pin_ff[i];
            end
         end
      end
   end
   assign PIN_OUT = pin_ff;

   // read port: data stand in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_ff <= 16'h0000;
      end else if (BUS.rd) begin
         if (BUS.addr < 6'h10) begin
            rdata_ff <= val_ff[BUS.addr[3:0]];
         end else if (BUS.addr < 6'h20) begin
            rdata_ff <= {8'h00, mode_ff[BUS.addr[3:0]]};
         end else begin
            case (BUS.addr)
               `DTCC_OFF_TA_CNT: rdata_ff <= tmr_ff[0];
               `DTCC_OFF_TA_REL: rdata_ff <= rel_ff[0];
               `DTCC_OFF_TB_CNT: rdata_ff <= tmr_ff[1];
               `DTCC_OFF_TB_REL: rdata_ff <= rel_ff[1];
               `DTCC_OFF_TA_CTL: rdata_ff <= {12'h000, tctl_ff[0]};
               `DTCC_OFF_TB_CTL: rdata_ff <= {12'h000, tctl_ff[1]};
               `DTCC_OFF_FLAGS: rdata_ff <= flag_ff;
               `DTCC_OFF_GLOBAL: rdata_ff <= {15'h0000, stag_ff};
               default: rdata_ff <= 16'h0000;
            endcase
         end
      end else begin
         rdata_ff <= 16'h0000;
      end
   end
   assign RDATA = rdata_ff;
endmodule
`default_nettype wire

/* verif/dtcc_assertions.sv */
// concurrent checks on the ports of the capture/compare array
`timescale 1ns/1ps
`default_nettype none
module dtcc_assertions (
   input wire logic CLK,
   input wire logic RST_B,
   input wire dtcc_pkg::dtcc_bus_type BUS,
   input wire logic [15:0] RDATA,
   input wire logic OVF_TICK,
   input wire logic EXT_COUNT,
   input wire logic [15:0] PIN_IN,
   input wire logic [15:0] PIN_OUT,
   input wire logic [15:0] PIN_OE
);
   import dtcc_pkg::*;
   dtcc_mode_type mode0_ff;
   logic [15:0] ta_ctl_ff;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // shadows of channel 0 mode and timer A control, rebuilt from bus writes
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode0_ff <= dtcc_mode_type'(8'h07);
         ta_ctl_ff <= 16'h0000;
      end else if (BUS.wr) begin
         if (BUS.addr == 6'h10) mode0_ff <= dtcc_mode_type'(BUS.wdata[7:0]);
         if (BUS.addr == 6'h24) ta_ctl_ff <= BUS.wdata;
      end
   end
   property p_rd_idle;
      !BUS.rd |=> RDATA == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
   property p_unmapped;
      BUS.rd && BUS.addr > 6'h27 |=> RDATA == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_mode_rb;
      BUS.wr && BUS.addr == 6'h10 ##1 BUS.rd && BUS.addr == 6'h10
         |=> RDATA[7:0] == $past(BUS.wdata[7:0], 2);
   endproperty
   a_mode_rb: assert property (p_mode_rb) else $error("mode readback differs");
   property p_rel_rb;
      BUS.wr && BUS.addr == 6'h21 ##1 BUS.rd && BUS.addr == 6'h21
         |=> RDATA == $past(BUS.wdata, 2);
   endproperty
   a_rel_rb: assert property (p_rel_rb) else $error("reload readback differs");
   // two reads in a row of a timer running on every clock must differ by one
   property p_cnt_inc;
      ta_ctl_ff == 16'h000D && BUS.rd && BUS.addr == 6'h20
         ##1 BUS.rd && BUS.addr == 6'h20 && RDATA != 16'hFFFF
         |=> RDATA == $past(RDATA) + 16'h0001;
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("timer A did not step by one");
   property p_capt_oe;
      mode0_ff.fn == DTCC_CAPT |-> PIN_OE[0] == 1'b0;
   endproperty
   a_capt_oe: assert property (p_capt_oe) else $error("capture pin driven");
   property p_cmp0;
      mode0_ff.fn == DTCC_CMP0 && !mode0_ff.dbl && $stable(mode0_ff) |-> $stable(PIN_OUT[0]);
   endproperty
   a_cmp0: assert property (p_cmp0) else $error("mode 0 moved the pin");
   property p_rst_out;
      $rose(RST_B) |-> PIN_OUT == 16'h0000 && PIN_OE == 16'h0000;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("pins not idle after reset");
endmodule
`default_nettype wire

/* verif/dtcc_far.sv */
// far side model: pin wire levels, general timer overflow ticks, external count
`timescale 1ns/1ps
`default_nettype none
module dtcc_far (
   input wire logic clk,
   input wire logic ovf_en,
   input wire logic ext_en,
   input wire logic [15:0] pin_level,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   output logic ovf_tick = 1'b0,
   output logic ext_count = 1'b0,
   output logic [15:0] pin_in
);
   logic [2:0] div_ff = 3'h0;
   // a driven pin shows the block's level, a released one the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_level);
   // pulses every five clocks so counts do not line up with any prescaler
   always @(posedge clk) begin
      div_ff <= (div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
      ovf_tick <= ovf_en && div_ff == 3'h4;
      if (!ext_en)
         ext_count <= 1'b0;
      else if (div_ff[0])
         ext_count <= !ext_count;
   end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the capture/compare array
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dtcc_pkg::*;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   dtcc_bus_type BUS = '0;
   logic [15:0] RDATA, PIN_IN, PIN_OUT, PIN_OE, n0, lvl = 16'h0000;
   logic ovf_en = 1'b0, ext_en = 1'b0, OVF_TICK, EXT_COUNT, ext_q = 1'b0;
   logic [15:0] n_ovf = 16'h0000, n_ext = 16'h0000;
   logic [34:0] rows [0:7];
   int mismatches = 0, n_tests = 0;
   always #5 CLK = ~CLK;
   dtcc_array i_dut (.CLK(CLK), .RST_B(RST_B), .BUS(BUS), .RDATA(RDATA), .OVF_TICK(OVF_TICK),
      .EXT_COUNT(EXT_COUNT), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
   dtcc_far i_far (.clk(CLK), .ovf_en(ovf_en), .ext_en(ext_en), .pin_level(lvl),
      .pin_out(PIN_OUT), .pin_oe(PIN_OE), .ovf_tick(OVF_TICK), .ext_count(EXT_COUNT),
      .pin_in(PIN_IN));
   // tallies of pulses the far side produced
   always @(posedge CLK) begin
      ext_q <= EXT_COUNT;
      if (OVF_TICK) n_ovf <= n_ovf + 16'h0001;
      if (EXT_COUNT && !ext_q) n_ext <= n_ext + 16'h0001;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("%0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // write strobe stays up until the next bus task replaces it
   task automatic wr(input logic [5:0] a, input logic [15:0] v);
      @(posedge CLK);
      BUS <= '{a, v, 1'b1, 1'b0};
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      @(posedge CLK);
      BUS <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge CLK);
      BUS <= '0;
      #1 chk(RDATA, exp);
   endtask
   task automatic idle(input int n);
      @(posedge CLK);
      BUS <= '0;
      repeat (n - 1) @(posedge CLK);
      #1;
   endtask
   task automatic rst;
      @(posedge CLK);
      RST_B <= 1'b0;
      repeat (2) @(posedge CLK);
      RST_B <= 1'b1;
   endtask
   task automatic cap(input logic [15:0] m, input logic [15:0] c, input logic v);
      wr(6'h20, c);
      wr(6'h10, m);
      idle(2);
      @(posedge CLK);
      lvl <= {15'h0000, v};
      idle(3);
   endtask
   initial begin
      repeat (20000) @(posedge CLK);
      mismatches++;
      test_done();
   end
   initial begin
      // ch0 mode, ch1 mode, pin 15, 25 and 29 cycles after the timer starts, flags
      rows = '{{8'h00, 8'h07, 3'h0, 16'h0001}, {8'h01, 8'h07, 3'h6, 16'h0001},
         {8'h02, 8'h07, 3'h0, 16'h0001}, {8'h03, 8'h07, 3'h5, 16'h0001},
         {8'h11, 8'h07, 3'h7, 16'h0001}, {8'h13, 8'h07, 3'h4, 16'h0001},
         {8'h09, 8'h07, 3'h0, 16'h0000}, {8'h21, 8'h21, 3'h2, 16'h0003}};
      repeat (8) @(posedge CLK);
      RST_B <= 1'b1;
      // timer A every clock over a 16-count period; hits at counts FFF3 and FFFA
      for (int i = 0; i < 8; i++) begin
         rst();
         wr(6'h21, 16'hFFF0);
         rd(6'h21, 16'hFFF0);
         wr(6'h20, 16'hFFF0);
         wr(6'h00, 16'hFFFA);
         wr(6'h01, 16'hFFF3);
         wr(6'h11, {8'h00, rows[i][26:19]});
         wr(6'h10, {8'h00, rows[i][34:27]});
         rd(6'h10, {8'h00, rows[i][34:27]});
         wr(6'h24, 16'h000D);
         idle(15);
         chk({15'h0000, PIN_OUT[0]}, {15'h0000, rows[i][18]});
         idle(10);
         chk({15'h0000, PIN_OUT[0]}, {15'h0000, rows[i][17]});
         idle(4);
         chk({15'h0000, PIN_OUT[0]}, {15'h0000, rows[i][16]});
         rd(6'h26, rows[i][15:0]);
         $display("compare row %0d done", i);
      end
      // back-to-back count reads while the timer runs
      @(posedge CLK);
      BUS <= '{6'h20, 16'h0000, 1'b0, 1'b1};
      repeat (2) @(posedge CLK);
      BUS <= '0;
      wr(6'h30, 16'hFFFF);
      rd(6'h30, 16'h0000);
      // capture on a stopped timer so the latched count is exact
      rst();
      cap(16'h0044, 16'h1234, 1'b1);
      rd(6'h00, 16'h1234);
      cap(16'h0044, 16'h2222, 1'b0);
      rd(6'h00, 16'h1234);
      cap(16'h00C4, 16'h3333, 1'b1);
      rd(6'h00, 16'h3333);
      cap(16'h0084, 16'h4444, 1'b0);
      rd(6'h00, 16'h4444);
      rd(6'h26, 16'h0001);
      wr(6'h26, 16'h0001);
      rd(6'h26, 16'h0000);
      $display("capture test done");
      // 128 clocks of run on both time bases: prescaled and staggered tick counts
      for (int s = 0; s < 5; s++) begin
         wr(6'h27, {15'h0000, s == 4});
         wr(6'(32 + 2 * (s % 2)), 16'h0000);
         wr(6'(36 + s % 2), {12'h000, (s == 4) ? 3'h6 : 3'(s), 1'b1});
         idle(127);
         wr(6'(36 + s % 2), 16'h0000);
         rd(6'(32 + 2 * (s % 2)), (s == 4) ? 16'h0010 : 16'(128 >> (s + 3)));
         $display("prescaler test %0d done", s);
      end
      // overflow ticks and external count as timer A clock
      for (int s = 4; s < 6; s++) begin
         rst();
         wr(6'h24, {12'h000, 3'(s), 1'b1});
         idle(2);
         n0 = (s == 4) ? n_ovf : n_ext;
         @(posedge CLK);
         ovf_en <= (s == 4);
         ext_en <= (s == 5);
         idle(40);
         @(posedge CLK);
         ovf_en <= 1'b0;
         ext_en <= 1'b0;
         idle(6);
         rd(6'h20, ((s == 4) ? n_ovf : n_ext) - n0);
         $display("source %0d test done", s);
      end
      test_done();
   end
endmodule
bind dtcc_array dtcc_assertions i_chk (.CLK(CLK), .RST_B(RST_B), .BUS(BUS), .RDATA(RDATA),
   .OVF_TICK(OVF_TICK), .EXT_COUNT(EXT_COUNT), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
   .PIN_OE(PIN_OE));
`default_nettype wire
